/* hdl/dsg_pkg.sv */
// types shared by the deep-sleep gating and soft reset slice
package dsg_pkg;

	// ----------------------------------------
	// power state, one-hot
	// ----------------------------------------
	typedef enum logic [2:0] {
		DSG_RUN   = 3'b001,
		DSG_SLEEP = 3'b010,
		DSG_DEEP  = 3'b100
	} dsg_power_type;

	typedef logic [7:0] dsg_port_type;

endpackage

/* hdl/dsg_regs.svh */
// register offsets, field positions, reset values and bus timing for the gating slice
`ifndef DSG_REGS_SVH
`define DSG_REGS_SVH

// ----------------------------------------
// register byte offsets within the window
// ----------------------------------------
`define DSG_OFF_SRC0       12'h040
`define DSG_OFF_AUTO_GATE  12'h060
`define DSG_OFF_INT_STAT   12'h070
`define DSG_OFF_INT_MASK   12'h074
`define DSG_OFF_RUN_GATE   12'h100
`define DSG_OFF_SLEEP_GATE 12'h118
`define DSG_OFF_DEEP_GATE  12'h128

// ----------------------------------------
// field positions
// ----------------------------------------
`define DSG_CAN_ZERO_BIT   24
`define DSG_WATCHDOG_BIT   3
`define DSG_AUTO_GATE_BIT  0
`define DSG_PORT_MSB       7

// ----------------------------------------
// reset values
// ----------------------------------------
`define DSG_GATE_RST       8'h00
`define DSG_INT_RST        8'h00
`define DSG_WORD_ZERO      32'h00000000

// ----------------------------------------
// timing: access phase wait states
// ----------------------------------------
`define DSG_WAIT_STATES    1

`endif

/* hdl/dsg_top.sv */
// port clock gating per power state, soft reset control and APB register slave
`include "dsg_regs.svh"

module dsg_top
	import dsg_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// power state and capability from system control
	input  wire logic        sleepMode,
	input  wire logic        deepSleepMode,
	input  wire logic [31:0] capWord1,
	// port access requests from the bus fabric
	input  wire logic [7:0]  portAccess,
	output logic      [7:0]  portFault,
	// port clock enables and peripheral resets
	output logic      [7:0]  portClockEnable,
	output logic             canUnitZeroSoftReset,
	output logic             watchdogSoftReset,
	// interrupt
	output logic             irq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	dsg_power_type powerState_q;
	dsg_power_type powerState_d;
	dsg_port_type  runGate_q;
	dsg_port_type  sleepGate_q;
	dsg_port_type  deepGate_q;
	dsg_port_type  portClockEnable_q;
	dsg_port_type  portClockEnable_d;
	dsg_port_type  portFault_q;
	dsg_port_type  intStatus_q;
	dsg_port_type  intStatus_d;
	dsg_port_type  intMask_q;
	logic          autoGate_q;
	logic          canRst_q;
	logic          watchdogRst_q;
	logic          irq_q;
	logic          pready_q;
	logic          pslverr_q;
	logic [31:0]   prdata_q;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	wire accessPhase = psel & penable;
	wire startAccess = accessPhase & ~pready_q;
	wire wrEn        = accessPhase & pready_q & pwrite;
	wire selSrc      = (paddr == `DSG_OFF_SRC0);
	wire selAuto     = (paddr == `DSG_OFF_AUTO_GATE);
	wire selStat     = (paddr == `DSG_OFF_INT_STAT);
	wire selMask     = (paddr == `DSG_OFF_INT_MASK);
	wire selRun      = (paddr == `DSG_OFF_RUN_GATE);
	wire selSleep    = (paddr == `DSG_OFF_SLEEP_GATE);
	wire selDeep     = (paddr == `DSG_OFF_DEEP_GATE);
	wire selAny      = selSrc | selAuto | selStat | selMask | selRun | selSleep | selDeep;

	// write strobes per register
	wire wrSrc   = wrEn & selSrc;
	wire wrAuto  = wrEn & selAuto;
	wire wrStat  = wrEn & selStat;
	wire wrMask  = wrEn & selMask;
	wire wrRun   = wrEn & selRun;
	wire wrSleep = wrEn & selSleep;
	wire wrDeep  = wrEn & selDeep;

	// capability masking: a missing unit keeps its bit at its old value
	wire canWrOk      = capWord1[`DSG_CAN_ZERO_BIT];
	wire watchdogWrOk = capWord1[`DSG_WATCHDOG_BIT];

	// reset control word, reserved bits tied low
	wire [31:0] srcWord = {7'h00, canRst_q, 20'h00000, watchdogRst_q, 3'h0};

	// read mux; unmapped offsets return zero with an error
	wire [31:0] rdMux =
		selSrc   ? srcWord :
		selAuto  ? {31'h00000000, autoGate_q} :
		selStat  ? {24'h000000, intStatus_q} :
		selMask  ? {24'h000000, intMask_q} :
		selRun   ? {24'h000000, runGate_q} :
		selSleep ? {24'h000000, sleepGate_q} :
		selDeep  ? {24'h000000, deepGate_q} :
		`DSG_WORD_ZERO;

	// ----------------------------------------
	// apb handshake: one wait state, answer registered
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= `DSG_WORD_ZERO;
		end else begin
			pready_q  <= startAccess;
			pslverr_q <= startAccess & ~selAny;
			prdata_q  <= (startAccess & ~pwrite) ? rdMux : `DSG_WORD_ZERO;
		end
	end

	// ----------------------------------------
	// gating registers
	// ----------------------------------------
	// only the low byte is stored, so upper bits cannot be written
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			runGate_q   <= `DSG_GATE_RST;
			sleepGate_q <= `DSG_GATE_RST;
			deepGate_q  <= `DSG_GATE_RST;
		end else begin
			if (wrRun)
				runGate_q <= pwdata[`DSG_PORT_MSB:0];
			if (wrSleep)
				sleepGate_q <= pwdata[`DSG_PORT_MSB:0];
			if (wrDeep)
				deepGate_q <= pwdata[`DSG_PORT_MSB:0];
		end
	end

	// auto gating select
	always_ff @(posedge sys_clk) begin
		if (reset)
			autoGate_q <= 1'b0;
		else if (wrAuto)
			autoGate_q <= pwdata[`DSG_AUTO_GATE_BIT];
	end

	// ----------------------------------------
	// soft reset control
	// ----------------------------------------
	// the held bit is the reset itself; software clears it to release
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			canRst_q      <= 1'b0;
			watchdogRst_q <= 1'b0;
		end else begin
			if (wrSrc & canWrOk)
				canRst_q <= pwdata[`DSG_CAN_ZERO_BIT];
			if (wrSrc & watchdogWrOk)
				watchdogRst_q <= pwdata[`DSG_WATCHDOG_BIT];
		end
	end

	// ----------------------------------------
	// power state tracking
	// ----------------------------------------
	// deep sleep wins if both requests are up
	always_comb begin
		case ({deepSleepMode, sleepMode})
			2'b00:   powerState_d = DSG_RUN;
			2'b01:   powerState_d = DSG_SLEEP;
			2'b10:   powerState_d = DSG_DEEP;
			2'b11:   powerState_d = DSG_DEEP;
			default: powerState_d = DSG_RUN;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset)
			powerState_q <= DSG_RUN;
		else
			powerState_q <= powerState_d;
	end

	// gating selection; without auto gating the run set always applies
	always_comb begin
		case (powerState_q)
			DSG_RUN:   portClockEnable_d = runGate_q;
			DSG_SLEEP: portClockEnable_d = autoGate_q ? sleepGate_q : runGate_q;
			DSG_DEEP:  portClockEnable_d = autoGate_q ? deepGate_q : runGate_q;
			default:   portClockEnable_d = runGate_q;
		endcase
	end

	// registered enable keeps glitches off the clock gates
	always_ff @(posedge sys_clk) begin
		if (reset)
			portClockEnable_q <= `DSG_GATE_RST;
		else
			portClockEnable_q <= portClockEnable_d;
	end

	// ----------------------------------------
	// bus fault and sticky status per port
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi <= `DSG_PORT_MSB; gi++) begin : g_port
			// hardware set beats a software clear in the same cycle
			assign intStatus_d[gi] = portFault_q[gi] |
				(intStatus_q[gi] & ~(wrStat & pwdata[gi]));
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					portFault_q[gi] <= 1'b0;
					intStatus_q[gi] <= 1'b0;
				end else begin
					portFault_q[gi] <= portAccess[gi] & ~portClockEnable_q[gi];
					intStatus_q[gi] <= intStatus_d[gi];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// interrupt mask and output
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			intMask_q <= `DSG_INT_RST;
			irq_q     <= 1'b0;
		end else begin
			if (wrMask)
				intMask_q <= pwdata[`DSG_PORT_MSB:0];
			irq_q <= |(intStatus_q & intMask_q);
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign prdata               = prdata_q;
	assign pready               = pready_q;
	assign pslverr              = pslverr_q;
	assign portFault            = portFault_q;
	assign portClockEnable      = portClockEnable_q;
	assign canUnitZeroSoftReset = canRst_q;
	assign watchdogSoftReset    = watchdogRst_q;
	assign irq                  = irq_q;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (reset);

	a_gate_reset_zero: assert property (
		$past(reset) |-> (portClockEnable_q == 8'h00 && deepGate_q == 8'h00))
		else $error("gating not zero after reset");

	a_deep_gate_write: assert property (
		wrDeep |=> deepGate_q == $past(pwdata[7:0]))
		else $error("deep gating write lost");

	a_deep_select: assert property (
		(powerState_q == DSG_DEEP && autoGate_q) |=> portClockEnable_q == $past(deepGate_q))
		else $error("deep set not applied in deep sleep");

	a_sleep_select: assert property (
		(powerState_q == DSG_SLEEP && autoGate_q) |=> portClockEnable_q == $past(sleepGate_q))
		else $error("sleep set not applied in sleep");

	a_run_select: assert property (
		(powerState_q == DSG_RUN) |=> portClockEnable_q == $past(runGate_q))
		else $error("run set not applied in run");

	a_no_auto_run: assert property (
		!autoGate_q |=> portClockEnable_q == $past(runGate_q))
		else $error("run set not applied without auto gating");

	a_fault_gated: assert property (
		1'b1 |=> portFault_q == $past(portAccess & ~portClockEnable_q))
		else $error("fault does not match gated access");

	a_status_sticky: assert property (
		(|portFault_q) |=> (intStatus_q & $past(portFault_q)) == $past(portFault_q))
		else $error("fault event lost from status");

	a_deep_read_upper: assert property (
		(pready_q && $past(psel && !pwrite && paddr == `DSG_OFF_DEEP_GATE)) |-> prdata_q[31:8] == 24'h000000)
		else $error("deep gating upper bits not zero");

	a_src_reserved: assert property (
		pready_q |-> ((prdata_q & 32'hFEFFFFF7) == 32'h00000000 || !$past(selSrc))
		|| $past(selSrc) == 1'b0)
		else $error("reset register reserved bits set");

	a_cap_mask: assert property (
		(wrSrc && !capWord1[`DSG_CAN_ZERO_BIT]) |=> canRst_q == $past(canRst_q))
		else $error("can reset written without capability");

	a_cap_mask_dog: assert property (
		(wrSrc && !capWord1[`DSG_WATCHDOG_BIT]) |=> watchdogRst_q == $past(watchdogRst_q))
		else $error("watchdog reset written without capability");

	a_can_write: assert property (
		(wrSrc && capWord1[`DSG_CAN_ZERO_BIT]) |=> canUnitZeroSoftReset == $past(pwdata[24]))
		else $error("can reset bit not written");

	a_dog_write: assert property (
		(wrSrc && capWord1[`DSG_WATCHDOG_BIT]) |=> watchdogSoftReset == $past(pwdata[3]))
		else $error("watchdog reset bit not written");

	a_reset_held: assert property (
		(canRst_q && !wrSrc) |=> canUnitZeroSoftReset)
		else $error("can reset released without a write");

	a_enable_gates: assert property (
		(portClockEnable_d == 8'h00) |=> portClockEnable == 8'h00)
		else $error("port clock enabled while gated");

	a_ready_pulse: assert property (
		startAccess |=> pready_q ##1 !pready_q)
		else $error("ready not a single cycle");

	a_irq_level: assert property (
		(|(intStatus_q & intMask_q)) |=> irq_q)
		else $error("interrupt not raised");

	// write one to clear must drop the written bits when no new fault arrives
	a_stat_clear: assert property (
		(wrStat && !(|portFault_q)) |=> (intStatus_q & $past(pwdata[7:0])) == 8'h00)
		else $error("status bit not cleared by write");

	c_deep_fault: cover property (
		powerState_q == DSG_DEEP && autoGate_q ##1 (|portFault_q));
	c_can_reset: cover property (
		wrSrc && capWord1[`DSG_CAN_ZERO_BIT] && pwdata[24]);
	c_sleep_sel: cover property (
		powerState_q == DSG_SLEEP && autoGate_q && sleepGate_q != runGate_q);
	c_irq_raise: cover property (
		$rose(irq_q));

endmodule

/* verif/dsg_top_bench.sv */
// self-checking bench for the deep-sleep gating and soft reset slice
`include "dsg_regs.svh"

module dsg_top_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic        sys_clk, reset, psel, penable, pwrite, sleepMode, deepSleepMode;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, capWord1;
	logic        pready, pslverr, canUnitZeroSoftReset, watchdogSoftReset, irq;
	logic [7:0]  portAccess, portFault, portClockEnable;
	int          fails, checkCount, seed;
	logic [31:0] gr, gs, gd, rv;
	logic        ev;

	dsg_top i_dsg_top (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleepMode(sleepMode), .deepSleepMode(deepSleepMode), .capWord1(capWord1),
		.portAccess(portAccess), .portFault(portFault), .portClockEnable(portClockEnable),
		.canUnitZeroSoftReset(canUnitZeroSoftReset), .watchdogSoftReset(watchdogSoftReset), .irq(irq));

	// ----------------------------------------
	// clock, verdict and comparison
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	task automatic test_done();
		if (fails == 0 && checkCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
		checkCount++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s: saw %h expected %h", $time, m, seen, exp);
		end
	endtask

	task automatic wt(input int k);
		repeat (k) @(posedge sys_clk);
	endtask

	// ----------------------------------------
	// apb master: entered just after an edge, leaves one idle edge so psel is never set twice at once
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			$display("[FAIL] %0t no pready", $time);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rv, ev);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string m);
		apb(1'b0, a, 32'h0, rv, ev);
		chk(rv, exp, m);
	endtask

	task automatic mode(input logic s, input logic d);
		sleepMode <= s;
		deepSleepMode <= d;
		wt(3);
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{reset, psel, penable, pwrite, sleepMode, deepSleepMode} = 6'h20;
		{paddr, pwdata, capWord1, portAccess} = '0;
		fails = 0;
		checkCount = 0;
		seed = 32'h52F2;
		wt(8);
		reset <= 1'b0;
		wt(2);
		chk({24'h0, portClockEnable}, 32'h0, "gating after reset");
		rdchk(`DSG_OFF_DEEP_GATE, 32'h0, "deep reset value");
		rdchk(`DSG_OFF_SRC0, 32'h0, "soft reset value");
		// corner patterns first, then random gating sets with junk in the reserved bits
		for (int k = 0; k < 6; k++) begin
			gr = $random(seed);
			gs = $random(seed);
			gd = (k == 0) ? 32'hFFFFFF00 : (k == 1) ? 32'h000000FF : $random(seed);
			wr(`DSG_OFF_RUN_GATE, gr);
			wr(`DSG_OFF_SLEEP_GATE, gs);
			wr(`DSG_OFF_DEEP_GATE, gd);
			rdchk(`DSG_OFF_DEEP_GATE, {24'h0, gd[7:0]}, "deep readback");
			rdchk(`DSG_OFF_SLEEP_GATE, {24'h0, gs[7:0]}, "sleep readback");
			mode(1'b0, 1'b0);
			chk({24'h0, portClockEnable}, {24'h0, gr[7:0]}, "run set");
			wr(`DSG_OFF_AUTO_GATE, 32'h0);
			mode(1'b1, 1'b0);
			chk({24'h0, portClockEnable}, {24'h0, gr[7:0]}, "sleep without auto");
			mode(1'b0, 1'b1);
			chk({24'h0, portClockEnable}, {24'h0, gr[7:0]}, "deep without auto");
			wr(`DSG_OFF_AUTO_GATE, 32'h1);
			wt(2);
			chk({24'h0, portClockEnable}, {24'h0, gd[7:0]}, "deep set");
			mode(1'b1, 1'b0);
			chk({24'h0, portClockEnable}, {24'h0, gs[7:0]}, "sleep set");
			mode(1'b1, 1'b1);
			// one access to every port; only the gated ones may fault
			portAccess <= 8'hFF;
			@(posedge sys_clk);
			portAccess <= 8'h00;
			@(posedge sys_clk);
			chk({24'h0, portFault}, {24'h0, ~gd[7:0]}, "port fault");
			wt(3);
			chk({31'h0, irq}, 32'h0, "irq masked");
			rdchk(`DSG_OFF_INT_STAT, {24'h0, ~gd[7:0]}, "fault status");
			wr(`DSG_OFF_INT_MASK, 32'hFF);
			wt(2);
			chk({31'h0, irq}, {31'h0, |(~gd[7:0])}, "irq raised");
			wr(`DSG_OFF_INT_STAT, 32'hFF);
			wt(2);
			chk({31'h0, irq}, 32'h0, "irq cleared");
			wr(`DSG_OFF_INT_MASK, 32'h0);
		end
		// soft reset writes against growing capability
		wr(`DSG_OFF_SRC0, 32'hFFFFFFFF);
		rdchk(`DSG_OFF_SRC0, 32'h0, "masked by capability");
		capWord1 <= 32'h01000000;
		wr(`DSG_OFF_SRC0, 32'hFFFFFFFF);
		rdchk(`DSG_OFF_SRC0, 32'h01000000, "can only");
		chk({30'h0, canUnitZeroSoftReset, watchdogSoftReset}, 32'h2, "can held");
		capWord1 <= $random(seed) | 32'h01000008;
		wr(`DSG_OFF_SRC0, 32'hFFFFFFFF);
		rdchk(`DSG_OFF_SRC0, 32'h01000008, "both bits");
		chk({30'h0, canUnitZeroSoftReset, watchdogSoftReset}, 32'h3, "both held");
		wr(`DSG_OFF_SRC0, 32'h0);
		wt(1);
		chk({30'h0, canUnitZeroSoftReset, watchdogSoftReset}, 32'h0, "released");
		// unmapped place answers with an error and reads zero
		apb(1'b0, 12'h044, 32'h0, rv, ev);
		chk({31'h0, ev}, 32'h1, "unmapped error");
		chk(rv, 32'h0, "unmapped read");
		// mid-run reset clears everything again
		wr(`DSG_OFF_DEEP_GATE, 32'hA5);
		reset <= 1'b1;
		wt(2);
		reset <= 1'b0;
		wt(1);
		rdchk(`DSG_OFF_DEEP_GATE, 32'h0, "second reset");
		test_done();
	end
endmodule
